// ### rtl/grf_pkg.sv
// Package for the general register file: sizes, operand codes, reset values.
// Assumes one CPU clock and a synchronous active-low reset in every user.
`default_nettype none
package grf_pkg;
	localparam int REG_COUNT = 8;
	localparam int REG_WIDTH = 32;
	localparam int HALF_WIDTH = 16;
	localparam int BYTE_WIDTH = 8;
	localparam int SEL_WIDTH = 3;
	localparam logic [2:0] STACK_INDEX = 3'h7;
	localparam logic [31:0] REG_RESET = 32'h00000000;
	// Operand selector: which portion of a register is accessed
	typedef enum logic [2:0] {
		GRF_WORD,
		GRF_UPPER_HALF,
		GRF_LOWER_HALF,
		GRF_HIGH_BYTE,
		GRF_LOW_BYTE
	} grf_size_t;
	localparam logic [2:0] SIZE_ILLEGAL_MIN = 3'h5;
endpackage : grf_pkg
`default_nettype wire

// ### rtl/grf_regfile.sv
// General register file: eight 32-bit registers with word, half and byte ports.
// Assumes the datapath drives ports synchronously to REF_CLK_I.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Eight identical 32-bit registers usable as address or data registers.
// - Data accesses may be 32-bit word, 16-bit half or 8-bit byte.
// - Each register splits into upper and lower 16-bit halves, sixteen halves.
// - Each lower half splits into high and low bytes, sixteen bytes.
// - Size chosen for one register portion is independent of all others.
// - Register seven is also the stack pointer, used by calls and exceptions.
module grf_regfile #(
	parameter int NUM_REGS = grf_pkg::REG_COUNT
) (
	input wire logic REF_CLK_I, // CPU clock
	input wire logic RSTN_I, // Synchronous reset, active low
	input wire logic [2:0] RD_A_SEL_I, // Read port A register index
	input wire logic [2:0] RD_A_SIZE_I, // Read port A operand portion
	input wire logic [2:0] RD_B_SEL_I, // Read port B register index
	input wire logic [2:0] RD_B_SIZE_I, // Read port B operand portion
	input wire logic WR_EN_I, // Write strobe
	input wire logic [2:0] WR_SEL_I, // Write register index
	input wire logic [2:0] WR_SIZE_I, // Write operand portion
	input wire logic [31:0] WR_DATA_I, // Write data, right aligned
	input wire logic SP_WR_EN_I, // Implicit stack pointer write
	input wire logic [31:0] SP_WR_DATA_I, // Stack pointer new value
	output logic [31:0] RD_A_DATA_O, // Port A data, zero extended
	output logic [31:0] RD_B_DATA_O, // Port B data, zero extended
	output logic [31:0] SP_O // Current stack pointer
);
	// Storage; entry seven doubles as the stack pointer
	logic [31:0] regs_q [NUM_REGS];
	logic [31:0] rd_a_d;
	logic [31:0] rd_b_d;

	// Extract a portion, right aligned and zero extended
	function automatic logic [31:0] pick(input logic [31:0] r, input logic [2:0] sz);
		logic [31:0] v;
		v = 32'h00000000;
		unique case (sz)
			grf_pkg::GRF_WORD: v = r;
			grf_pkg::GRF_UPPER_HALF: v = {16'h0000, r[31:16]};
			grf_pkg::GRF_LOWER_HALF: v = {16'h0000, r[15:0]};
			grf_pkg::GRF_HIGH_BYTE: v = {24'h000000, r[15:8]};
			grf_pkg::GRF_LOW_BYTE: v = {24'h000000, r[7:0]};
			default: v = 32'h00000000;
		endcase
		return v;
	endfunction : pick

	// Merge write data into the addressed portion only
	function automatic logic [31:0] merge(input logic [31:0] r, input logic [2:0] sz,
		input logic [31:0] w);
		logic [31:0] v;
		v = r;
		unique case (sz)
			grf_pkg::GRF_WORD: v = w;
			grf_pkg::GRF_UPPER_HALF: v[31:16] = w[15:0];
			grf_pkg::GRF_LOWER_HALF: v[15:0] = w[15:0];
			grf_pkg::GRF_HIGH_BYTE: v[15:8] = w[7:0];
			grf_pkg::GRF_LOW_BYTE: v[7:0] = w[7:0];
			default: v = r;
		endcase
		return v;
	endfunction : merge

	// Register update; datapath write wins over implicit stack write
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_q[i] <= grf_pkg::REG_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				if (WR_EN_I && WR_SEL_I == 3'(i)) begin
					regs_q[i] <= merge(regs_q[i], WR_SIZE_I, WR_DATA_I);
				end else if (SP_WR_EN_I && grf_pkg::STACK_INDEX == 3'(i)) begin
					regs_q[i] <= SP_WR_DATA_I;
				end
			end
		end
	end

	// Next read data from stored contents; a same-edge write is not forwarded
	always_comb begin
		rd_a_d = pick(regs_q[RD_A_SEL_I], RD_A_SIZE_I);
		rd_b_d = pick(regs_q[RD_B_SEL_I], RD_B_SIZE_I);
	end

	// Registered read and stack pointer outputs, one cycle after select
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			RD_A_DATA_O <= grf_pkg::REG_RESET;
			RD_B_DATA_O <= grf_pkg::REG_RESET;
			SP_O <= grf_pkg::REG_RESET;
		end else begin
			RD_A_DATA_O <= rd_a_d;
			RD_B_DATA_O <= rd_b_d;
			SP_O <= regs_q[grf_pkg::STACK_INDEX];
		end
	end

	// Half write keeps the other half
	half_keep_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		WR_EN_I && WR_SIZE_I == grf_pkg::GRF_LOWER_HALF
		|=> regs_q[$past(WR_SEL_I)][31:16] == $past(regs_q[WR_SEL_I][31:16])
		&& regs_q[$past(WR_SEL_I)][15:0] == $past(WR_DATA_I[15:0]))
		else $error("lower half write disturbed upper half");
	// Byte write keeps other bits
	byte_keep_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		WR_EN_I && WR_SIZE_I == grf_pkg::GRF_HIGH_BYTE
		|=> regs_q[$past(WR_SEL_I)][31:16] == $past(regs_q[WR_SEL_I][31:16])
		&& regs_q[$past(WR_SEL_I)][7:0] == $past(regs_q[WR_SEL_I][7:0])
		&& regs_q[$past(WR_SEL_I)][15:8] == $past(WR_DATA_I[7:0]))
		else $error("high byte write wrong");
	// Word write then read back
	sequence word_wr_s;
		WR_EN_I && WR_SIZE_I == grf_pkg::GRF_WORD;
	endsequence
	word_read_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		word_wr_s ##1 (RD_A_SEL_I == $past(WR_SEL_I) && RD_A_SIZE_I == grf_pkg::GRF_WORD)
		|=> RD_A_DATA_O == $past(WR_DATA_I, 2))
		else $error("word readback mismatch");
	// Upper half read aligned
	upper_read_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		RD_B_SIZE_I == grf_pkg::GRF_UPPER_HALF
		|=> RD_B_DATA_O == {16'h0000, $past(regs_q[RD_B_SEL_I][31:16])})
		else $error("upper half read wrong");
	// Low byte read aligned
	low_byte_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		RD_A_SIZE_I == grf_pkg::GRF_LOW_BYTE
		|=> RD_A_DATA_O == {24'h000000, $past(regs_q[RD_A_SEL_I][7:0])})
		else $error("low byte read wrong");
	// Register zero untouched by a write aimed at another register
	others_keep_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		WR_EN_I && !SP_WR_EN_I && WR_SEL_I != 3'h0 |=> $stable(regs_q[0]))
		else $error("unaddressed register changed");
	// Implicit stack write lands in register seven
	sequence sp_only_s;
		SP_WR_EN_I && !(WR_EN_I && WR_SEL_I == grf_pkg::STACK_INDEX);
	endsequence
	sp_write_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		sp_only_s |=> ##1 SP_O == $past(SP_WR_DATA_I, 2))
		else $error("stack pointer write lost");
	// Stack pointer output mirrors register seven
	sp_mirror_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		1'b1 |=> SP_O == $past(regs_q[7]))
		else $error("stack pointer output stale");

	// Upper half write keeps the lower half
	upper_keep_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		WR_EN_I && WR_SIZE_I == grf_pkg::GRF_UPPER_HALF
		|=> regs_q[$past(WR_SEL_I)][15:0] == $past(regs_q[WR_SEL_I][15:0])
		&& regs_q[$past(WR_SEL_I)][31:16] == $past(WR_DATA_I[15:0]))
		else $error("upper half write disturbed lower half");
	// Low byte write keeps the other three bytes
	low_keep_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		WR_EN_I && WR_SIZE_I == grf_pkg::GRF_LOW_BYTE
		|=> regs_q[$past(WR_SEL_I)][31:8] == $past(regs_q[WR_SEL_I][31:8])
		&& regs_q[$past(WR_SEL_I)][7:0] == $past(WR_DATA_I[7:0]))
		else $error("low byte write wrong");
	// Word write replaces all 32 bits
	word_write_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		WR_EN_I && WR_SIZE_I == grf_pkg::GRF_WORD
		|=> regs_q[$past(WR_SEL_I)] == $past(WR_DATA_I))
		else $error("word write lost");
	// Unused portion codes leave the register as it was
	bad_size_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		WR_EN_I && WR_SIZE_I >= grf_pkg::SIZE_ILLEGAL_MIN
		|=> regs_q[$past(WR_SEL_I)] == $past(regs_q[WR_SEL_I]))
		else $error("unused size code changed a register");
	// Every register holds its value unless a write is aimed at it
	for (genvar g = 0; g < NUM_REGS; g++) begin : keep_g
		reg_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
			!(WR_EN_I && WR_SEL_I == 3'(g))
			&& !(SP_WR_EN_I && grf_pkg::STACK_INDEX == 3'(g))
			|=> $stable(regs_q[g]))
			else $error("register changed without a write");
	end

	// Unused portion codes read as zero on both ports
	zero_read_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		RD_A_SIZE_I >= grf_pkg::SIZE_ILLEGAL_MIN |=> RD_A_DATA_O == 32'h00000000)
		else $error("unused size code read non-zero on port A");
	zero_read_b_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		RD_B_SIZE_I >= grf_pkg::SIZE_ILLEGAL_MIN |=> RD_B_DATA_O == 32'h00000000)
		else $error("unused size code read non-zero on port B");
	// Port A high byte comes down to bits 7:0
	high_byte_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		RD_A_SIZE_I == grf_pkg::GRF_HIGH_BYTE
		|=> RD_A_DATA_O == {24'h000000, $past(regs_q[RD_A_SEL_I][15:8])})
		else $error("high byte read wrong");
	// Port B lower half and full word reads
	lower_read_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		RD_B_SIZE_I == grf_pkg::GRF_LOWER_HALF
		|=> RD_B_DATA_O == {16'h0000, $past(regs_q[RD_B_SEL_I][15:0])})
		else $error("lower half read wrong");
	word_read_b_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		RD_B_SIZE_I == grf_pkg::GRF_WORD |=> RD_B_DATA_O == $past(regs_q[RD_B_SEL_I]))
		else $error("port B word read wrong");
	// Port A upper half and port B low byte reads
	upper_a_read_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		RD_A_SIZE_I == grf_pkg::GRF_UPPER_HALF
		|=> RD_A_DATA_O == {16'h0000, $past(regs_q[RD_A_SEL_I][31:16])})
		else $error("port A upper half read wrong");
	low_b_read_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		RD_B_SIZE_I == grf_pkg::GRF_LOW_BYTE
		|=> RD_B_DATA_O == {24'h000000, $past(regs_q[RD_B_SEL_I][7:0])})
		else $error("port B low byte read wrong");

	// Register seven moves only on a write aimed at it
	stack_keep_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		!SP_WR_EN_I && !(WR_EN_I && WR_SEL_I == grf_pkg::STACK_INDEX)
		|=> $stable(regs_q[grf_pkg::STACK_INDEX]))
		else $error("stack pointer changed without a write");
	// Datapath word write to register seven beats the implicit stack write
	sp_priority_a: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
		WR_EN_I && SP_WR_EN_I && WR_SEL_I == grf_pkg::STACK_INDEX
		&& WR_SIZE_I == grf_pkg::GRF_WORD
		|=> regs_q[grf_pkg::STACK_INDEX] == $past(WR_DATA_I))
		else $error("stack write overrode datapath write");
	// Reset clears outputs and registers zero and seven; watched while reset is low
	reset_clear_a: assert property (@(posedge REF_CLK_I) !RSTN_I
		|=> RD_A_DATA_O == grf_pkg::REG_RESET && RD_B_DATA_O == grf_pkg::REG_RESET
		&& SP_O == grf_pkg::REG_RESET && regs_q[0] == grf_pkg::REG_RESET
		&& regs_q[grf_pkg::STACK_INDEX] == grf_pkg::REG_RESET)
		else $error("reset left a non-zero value");
endmodule : grf_regfile

`default_nettype wire

// ### verif/grf_shadow.sv
// Shadow of the datapath's writes, giving the expected register contents.
// Assumes the bench drives writes just after the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module grf_shadow (
	input wire logic clk_i, // CPU clock
	input wire logic rstn_i, // Reset, active low
	input wire logic wen_i, // Write strobe
	input wire logic [5:0] idx_i, // Register, portion
	input wire logic [31:0] wd_i, // Write data
	input wire logic spen_i, // Implicit stack write
	input wire logic [31:0] spd_i, // Stack write data
	output logic [31:0] regs_o [8] // Expected contents
);
	always_ff @(posedge clk_i) begin
		if (spen_i && !(wen_i && idx_i[5:3] == 3'h7)) regs_o[7] <= spd_i;
		if (wen_i) case (idx_i[2:0])
			3'h0: regs_o[idx_i[5:3]] <= wd_i;
			3'h1: regs_o[idx_i[5:3]][31:16] <= wd_i[15:0];
			3'h2: regs_o[idx_i[5:3]][15:0] <= wd_i[15:0];
			3'h3: regs_o[idx_i[5:3]][15:8] <= wd_i[7:0];
			3'h4: regs_o[idx_i[5:3]][7:0] <= wd_i[7:0];
			default: ;
		endcase
		if (!rstn_i) regs_o <= '{default: 32'h00000000};
	end
endmodule : grf_shadow
`default_nettype wire

// ### verif/cpu_general_register_file_test.sv
// Bench for the register file; the shadow model supplies expected contents.
// Assumes one 40 MHz clock; inputs change 2 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module cpu_general_register_file_test;
	logic clk, rstn, wen, spen;
	logic [2:0] asel, asz, bsel, bsz, wsel, wsz;
	logic [31:0] wd, spd, ad, bd, sp, bad_count, n_tests, ex [8];
	grf_regfile grf_regfile_i (.REF_CLK_I(clk), .RSTN_I(rstn), .RD_A_SEL_I(asel),
		.RD_A_SIZE_I(asz), .RD_B_SEL_I(bsel), .RD_B_SIZE_I(bsz), .WR_EN_I(wen),
		.WR_SEL_I(wsel), .WR_SIZE_I(wsz), .WR_DATA_I(wd), .SP_WR_EN_I(spen),
		.SP_WR_DATA_I(spd), .RD_A_DATA_O(ad), .RD_B_DATA_O(bd), .SP_O(sp));
	grf_shadow grf_shadow_i (.clk_i(clk), .rstn_i(rstn), .wen_i(wen), .idx_i({wsel, wsz}),
		.wd_i(wd), .spen_i(spen), .spd_i(spd), .regs_o(ex));
	initial forever #12.5 clk = ~clk;
	task automatic check(input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) bad_count++;
		if (seen !== exp) $display("wrong value at %0t: %h not %h", $time, seen, exp);
	endtask : check
	function automatic logic [31:0] pick(input logic [31:0] v, input logic [2:0] z);
		return z == 3'h0 ? v : z == 3'h1 ? v >> 16 : z == 3'h2 ? v & 32'h0000FFFF :
			z == 3'h3 ? v[15:8] : z == 3'h4 ? v[7:0] : 32'h00000000;
	endfunction : pick
	task automatic rd(input logic [2:0] r, input logic [2:0] z);
		{asel, asz, bsel, bsz} = {r, z, r ^ 3'h1, z};
		@(posedge clk) #2 check(ad, pick(ex[r], z));
		check(bd, pick(ex[r ^ 3'h1], z));
	endtask : rd
	task automatic t_portions;
		for (int i = 0; i < 8; i++) rd(3'(i), 3'h0);
		for (int i = 0; i < 64; i++)
			@(posedge clk) #2 {wen, wsel, wsz, wd} = {1'b1, 6'(i), 32'(32'h9E3779B9 * (i + 1))};
		@(posedge clk) #2 wen = 1'b0;
		for (int i = 0; i < 64; i++) rd(3'(i >> 3), 3'(i));
		check(sp, ex[7]);
		$display("portion test done");
	endtask : t_portions
	task automatic t_stack;
		{spen, spd} = {1'b1, 32'h0000FFF0};
		@(posedge clk) #2 spen = 1'b0;
		@(posedge clk) #2 check(sp, 32'h0000FFF0);
		check(sp, ex[7]);
		$display("stack test done");
	endtask : t_stack
	task automatic t_collide;
		{wen, wsel, wsz, wd, spen, spd} = {1'b1, 3'h7, 3'h0, 32'hA5C30F1E, 1'b1, 32'h00001234};
		@(posedge clk) #2 {wen, spen} = 2'h0;
		rd(3'h7, 3'h0);
		check(ad, 32'hA5C30F1E);
		check(sp, 32'hA5C30F1E);
		$display("collision test done");
	endtask : t_collide
	task automatic t_reset;
		rstn = 1'b0;
		@(posedge clk) #2 rstn = 1'b1;
		check(ad, 32'h00000000);
		check(bd, 32'h00000000);
		check(sp, 32'h00000000);
		rd(3'h7, 3'h0);
		$display("reset test done");
	endtask : t_reset
	task automatic close_out(input int late);
		bad_count += late;
		$display("%0d checks, %0d wrong", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	initial #20000 close_out(1);
	initial begin
		{clk, rstn, wen, spen, spd, wd, asel, asz, bsel, bsz, wsel, wsz, bad_count, n_tests} = 150'h0;
		#239.5 rstn = 1'b1;
		t_portions;
		t_stack;
		t_collide;
		t_reset;
		close_out(0);
	end
endmodule : cpu_general_register_file_test
`default_nettype wire
